// ### rtl/bsli_blink.sv
`timescale 1ns/1ps
module bsli_blink
    import bsli_pkg::*;
#(
    parameter int unsigned HALF = 4
)
(
    input  wire logic mclk,
    input  wire logic reset_n,
    input  wire logic restart,
    output logic      phase
);
    logic [BSLI_CNT_W-1:0] cnt_q;
    logic                  phase_q;
    wire                   wrap = (cnt_q == BSLI_CNT_W'(HALF - 1));
    wire                   phase_d = (!reset_n || restart) || (phase_q ^ wrap);

    always_ff @(posedge mclk)
    begin
        if (!reset_n || restart)
        begin
            cnt_q   <= '0;
            phase_q <= 1'b1;
        end
        else if (wrap)
        begin
            cnt_q   <= '0;
            phase_q <= ~phase_q;
        end
        else
            cnt_q <= cnt_q + 1'b1;
    end

    // Next phase goes out so the registered lamp keeps both halves equal on restart
    assign phase = phase_d;

    AST_HALF_PERIOD: assert property (@(posedge mclk) disable iff (!reset_n)
        $rose(phase_q) && !$past(restart) |-> $past(cnt_q) == BSLI_CNT_W'(HALF - 1))
        else $error("Blink phase toggled off count");
endmodule

// ### rtl/bsli_pkg.sv
package bsli_pkg;

    // Boot progress states reported by the controller firmware
    typedef enum logic [2:0]
    {
        BSLI_ST_NORMAL  = 3'h0,
        BSLI_ST_BOOTLDR = 3'h1,
        BSLI_ST_OSBOOT  = 3'h2,
        BSLI_ST_DONE    = 3'h3,
        BSLI_ST_FATAL   = 3'h4
    } bsli_state_t;

    // Status lamp colour pair
    typedef struct packed
    {
        logic green;
        logic amber;
    } bsli_status_t;

    // Lamp drive group
    typedef struct packed
    {
        logic         identify;
        bsli_status_t status;
    } bsli_lamps_t;

    localparam int unsigned BSLI_CLK_HZ       = 40000000;
    localparam int unsigned BSLI_FAST_BLINK_HZ = 3;
    localparam int unsigned BSLI_SLOW_BLINK_HZ = 1;
    // Half period in cycles, rounded down
    localparam int unsigned BSLI_FAST_HALF = BSLI_CLK_HZ / (2 * BSLI_FAST_BLINK_HZ);
    localparam int unsigned BSLI_SLOW_HALF = BSLI_CLK_HZ / (2 * BSLI_SLOW_BLINK_HZ);
    localparam int unsigned BSLI_CNT_W     = 25;
    localparam int unsigned BSLI_DONE_HOLD = 40000000;
    localparam logic [7:0]  BSLI_CODE_RST  = 8'h00;
    localparam int unsigned BSLI_CODE_W    = 8;

endpackage

// ### rtl/bsli_top.sv
`timescale 1ns/1ps
module bsli_top
    import bsli_pkg::*;
#(
    parameter int unsigned FAST_HALF = BSLI_FAST_HALF,
    parameter int unsigned SLOW_HALF = BSLI_SLOW_HALF,
    parameter int unsigned DONE_HOLD = BSLI_DONE_HOLD
)
(
    input  wire logic                   mclk,
    input  wire logic                   reset_n,
    input  wire logic                   power_on_evt,
    input  wire logic                   fw_update_evt,
    input  wire logic                   cold_reset_evt,
    input  wire logic                   watchdog_evt,
    input  wire logic                   mem_test_fail,
    input  wire logic                   loader_images_bad,
    input  wire logic                   os_handover,
    input  wire logic                   boot_complete,
    input  wire bsli_lamps_t            normal_lamps,
    input  wire logic                   code_wr,
    input  wire logic [BSLI_CODE_W-1:0] code_data,
    output bsli_lamps_t                 lamps,
    output logic [BSLI_CODE_W-1:0]      diag_lamps,
    output logic                        boot_active
);
    ////////////////////////////////////////////////////////////////////////////
    bsli_state_t           state_q;
    bsli_state_t           state_d;
    logic [31:0]           hold_q;
    bsli_lamps_t           lamps_q;
    bsli_lamps_t           lamps_d;
    logic [BSLI_CODE_W-1:0] code_q;
    logic                  fast_ph;
    logic                  slow_ph;
    logic                  armed_q;

    wire start_evt = power_on_evt || fw_update_evt || cold_reset_evt || watchdog_evt;
    wire fatal     = mem_test_fail || loader_images_bad;
    wire hold_end  = (hold_q == DONE_HOLD - 1);
    wire restart   = (state_d != state_q) || !armed_q;

    always_comb
    begin
        state_d = state_q;
        if (start_evt)
            state_d = BSLI_ST_BOOTLDR;
        else
        begin
            unique case (state_q)
                BSLI_ST_BOOTLDR:
                begin
                    if (fatal)
                        state_d = BSLI_ST_FATAL;
                    else if (os_handover)
                        state_d = BSLI_ST_OSBOOT;
                end
                BSLI_ST_OSBOOT:
                    if (boot_complete)
                        state_d = BSLI_ST_DONE;
                BSLI_ST_DONE:
                    if (hold_end)
                        state_d = BSLI_ST_NORMAL;
                BSLI_ST_FATAL:  state_d = BSLI_ST_FATAL;
                BSLI_ST_NORMAL: state_d = BSLI_ST_NORMAL;
                default:        state_d = BSLI_ST_NORMAL;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    bsli_blink #(.HALF(FAST_HALF)) u_fast
    (
        .mclk    (mclk),
        .reset_n (reset_n),
        .restart (restart),
        .phase   (fast_ph)
    );

    bsli_blink #(.HALF(SLOW_HALF)) u_slow
    (
        .mclk    (mclk),
        .reset_n (reset_n),
        .restart (restart),
        .phase   (slow_ph)
    );

    always_comb
    begin
        lamps_d = normal_lamps;
        unique case (state_d)
            BSLI_ST_FATAL:   lamps_d = '{identify: 1'b1, status: '{green: 1'b0, amber: 1'b1}};
            BSLI_ST_BOOTLDR:
                lamps_d = '{identify: fast_ph, status: '{green: slow_ph, amber: 1'b0}};
            BSLI_ST_OSBOOT:  lamps_d = '{identify: 1'b1, status: '{green: 1'b1, amber: 1'b0}};
            BSLI_ST_DONE:    lamps_d = '{identify: 1'b0, status: '{green: 1'b1, amber: 1'b0}};
            BSLI_ST_NORMAL:  lamps_d = normal_lamps;
            default:         lamps_d = normal_lamps;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Power-up counts as a boot, so reset enters the loader state
    always_ff @(posedge mclk)
    begin
        if (!reset_n)
        begin
            state_q <= BSLI_ST_BOOTLDR;
            hold_q  <= '0;
            lamps_q <= '0;
            armed_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            armed_q <= 1'b1;
            hold_q  <= (state_q == BSLI_ST_DONE && !restart) ? hold_q + 32'h1 : 32'h0;
            lamps_q <= lamps_d;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (!reset_n)
            code_q <= BSLI_CODE_RST;
        else if (code_wr)
            code_q <= code_data;
    end

    assign diag_lamps  = code_q;
    assign lamps       = lamps_q;
    assign boot_active = (state_q != BSLI_ST_NORMAL);

    ////////////////////////////////////////////////////////////////////////////
    AST_FATAL_LAMPS: assert property (@(posedge mclk) disable iff (!reset_n)
        state_q == BSLI_ST_FATAL |-> lamps.identify && lamps.status.amber && !lamps.status.green)
        else $error("Fatal pattern wrong");
    AST_LOADER_AMBER: assert property (@(posedge mclk) disable iff (!reset_n)
        state_d == BSLI_ST_BOOTLDR |=> !lamps.status.amber && lamps.identify == $past(fast_ph))
        else $error("Loader pattern wrong");
    AST_OS_SOLID: assert property (@(posedge mclk) disable iff (!reset_n)
        state_d == BSLI_ST_OSBOOT |=> lamps.identify && lamps.status.green)
        else $error("OS boot pattern wrong");
    AST_DONE_OFF: assert property (@(posedge mclk) disable iff (!reset_n)
        $rose(state_q == BSLI_ST_DONE) |-> !lamps.identify && lamps.status.green)
        else $error("Boot end pattern wrong");
    AST_START_EVT: assert property (@(posedge mclk) disable iff (!reset_n)
        start_evt |=> state_q == BSLI_ST_BOOTLDR)
        else $error("Reset sequence not entered");
    AST_NORMAL_PASS: assert property (@(posedge mclk) disable iff (!reset_n)
        state_d == BSLI_ST_NORMAL |=> lamps == $past(normal_lamps))
        else $error("Normal lamps not passed");
    AST_CODE_LATCH: assert property (@(posedge mclk) disable iff (!reset_n)
        code_wr |=> diag_lamps[0] == $past(code_data[0]) && diag_lamps[7] == $past(code_data[7]))
        else $error("Progress code not latched");
    AST_CODE_HOLD: assert property (@(posedge mclk) disable iff (!reset_n)
        !code_wr |=> $stable(diag_lamps))
        else $error("Progress code changed without write");

    COV_LOADER_TO_OS: cover property (@(posedge mclk) disable iff (!reset_n)
        state_q == BSLI_ST_BOOTLDR ##1 state_q == BSLI_ST_OSBOOT);
    COV_FATAL: cover property (@(posedge mclk) disable iff (!reset_n)
        state_q == BSLI_ST_FATAL);
    COV_BACK_NORMAL: cover property (@(posedge mclk) disable iff (!reset_n)
        state_q == BSLI_ST_DONE ##1 state_q == BSLI_ST_NORMAL);
endmodule

// ### testbench/bsli_lamp_model.sv
`timescale 1ns/1ps
module bsli_lamp_model
    import bsli_pkg::*;
(
    input  wire logic        mclk,
    input  wire bsli_lamps_t lamps,
    output int               id_half,
    output int               gr_half
);
    int          id_cnt = 0;
    int          gr_cnt = 0;
    bsli_lamps_t last_q = '0;
    wire logic   id_chg = lamps.identify !== last_q.identify;
    wire logic   gr_chg = lamps.status.green !== last_q.status.green;

    ////////////////////////////////////////////////////////////////
    // Lamp viewer: edges between lamp changes, as an eye sees blink
    always @(posedge mclk)
    begin
        last_q <= lamps;
        id_cnt <= id_chg ? 1 : id_cnt + 1;
        gr_cnt <= gr_chg ? 1 : gr_cnt + 1;
        if (id_chg)
            id_half <= id_cnt;
        if (gr_chg)
            gr_half <= gr_cnt;
    end
endmodule

// ### testbench/bsli_top_bench.sv
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin n_mismatch++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
module bsli_top_bench;
    import bsli_pkg::*;
    localparam int FH = 4;
    localparam int SH = 12;
    localparam int DH = 20;
    logic        mclk = 0;
    logic        reset_n = 0;
    logic [3:0]  evt = '0;
    logic [1:0]  fatal = '0;
    logic        handover = 0;
    logic        complete = 0;
    bsli_lamps_t normal = 3'h1;
    logic        code_wr = 0;
    logic [7:0]  code_data = 8'h00;
    bsli_lamps_t lamps;
    logic [7:0]  diag;
    logic        active;
    int          id_half;
    int          gr_half;
    int          n_mismatch = 0;
    int          checks = 0;
    int          cyc = 0;

    bsli_top #(.FAST_HALF(FH), .SLOW_HALF(SH), .DONE_HOLD(DH)) bsli_top_inst (
        .mclk(mclk), .reset_n(reset_n), .power_on_evt(evt[0]), .fw_update_evt(evt[1]),
        .cold_reset_evt(evt[2]), .watchdog_evt(evt[3]), .mem_test_fail(fatal[0]),
        .loader_images_bad(fatal[1]), .os_handover(handover), .boot_complete(complete),
        .normal_lamps(normal), .code_wr(code_wr), .code_data(code_data), .lamps(lamps),
        .diag_lamps(diag), .boot_active(active));
    bsli_lamp_model bsli_lamp_model_inst (
        .mclk(mclk), .lamps(lamps), .id_half(id_half), .gr_half(gr_half));

    ////////////////////////////////////////////////////////////////
    initial
    begin
        forever #12.5 mclk = ~mclk;
    end

    // Whole run is a few hundred cycles; ceiling leaves ample margin
    always @(posedge mclk)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            n_mismatch++;
            results();
        end
    end

    task automatic results();
        $display("checks=%0d n_mismatch=%0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic fire(input int i);
        @(posedge mclk);
        evt <= 4'h1 << i;
        @(posedge mclk);
        evt <= '0;
        #1;
    endtask

    ////////////////////////////////////////////////////////////////
    task automatic t_loader();
        repeat (40) @(posedge mclk);
        #1;
        `CHK(id_half, FH)
        `CHK(gr_half, SH)
        `CHK(lamps.status.amber, 1'b0)
        `CHK(active, 1'b1)
        `CHK(diag, 8'h00)
    endtask

    task automatic t_fatal(input int k);
        fire(2);
        @(posedge mclk);
        fatal <= 2'h1 << k;
        @(posedge mclk);
        fatal <= '0;
        #1;
        `CHK(lamps, 3'h5)
        repeat (3 * SH) @(posedge mclk);
        #1;
        `CHK(lamps, 3'h5)
    endtask

    task automatic t_boot(input int i);
        fire(i);
        `CHK(lamps, 3'h6)
        `CHK(active, 1'b1)
        @(posedge mclk);
        handover <= 1;
        @(posedge mclk);
        handover <= 0;
        fatal <= 2'h3;
        #1;
        `CHK(lamps, 3'h6)
        repeat (FH + 1) @(posedge mclk);
        fatal <= '0;
        #1;
        `CHK(lamps, 3'h6)
        `CHK(active, 1'b1)
        @(posedge mclk);
        complete <= 1;
        @(posedge mclk);
        complete <= 0;
        #1;
        `CHK(lamps, 3'h2)
        repeat (DH - 1) @(posedge mclk);
        #1;
        `CHK(lamps, 3'h2)
        @(posedge mclk);
        #1;
        `CHK(lamps, normal)
        `CHK(active, 1'b0)
    endtask

    task automatic t_code();
        logic [7:0] v [3] = '{8'h01, 8'h80, 8'h5a};
        foreach (v[j])
        begin
            @(posedge mclk);
            code_wr <= 1;
            code_data <= v[j];
            @(posedge mclk);
            #1;
            `CHK(diag, v[j])
        end
        @(posedge mclk);
        code_wr <= 0;
        code_data <= 8'hff;
        repeat (10) @(posedge mclk);
        #1;
        `CHK(diag, 8'h5a)
    endtask

    ////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (3) @(posedge mclk);
        reset_n <= 1;
        t_loader();
        t_fatal(0);
        t_fatal(1);
        for (int i = 0; i < 4; i++)
            t_boot(i);
        t_code();
        results();
    end
endmodule
